// ===== lpd_cfg.svh
/*
  Constants for the low-power DDR command link: command encodings,
  timing figures in their own units and their cycle counts.
  Assumes a 200 MHz core clock on both ends.
*/
`ifndef LPD_CFG_SVH
`define LPD_CFG_SVH

`define LPD_CLK_MHZ 200
// Row strobe, column strobe, write enable
`define LPD_RCW_NOP 3'h7
`define LPD_RCW_ACT 3'h3
`define LPD_RCW_RD 3'h5
`define LPD_RCW_WR 3'h4
`define LPD_RCW_BT 3'h6
`define LPD_RCW_PRE 3'h2
`define LPD_RCW_REF 3'h1
`define LPD_A10 10
`define LPD_PARTIAL_ARRAY_REFRESH_SETTING_HALF 3'h1
`define LPD_PARTIAL_ARRAY_REFRESH_SETTING_QUARTER 3'h2
`define LPD_BANKS_ALL 4'hF
`define LPD_BANKS_HALF 4'h3
`define LPD_BANKS_QUARTER 4'h1
// Timing in ns, counts rounded up
`define LPD_TRP_NS 15
`define LPD_TRAS_NS 40
`define LPD_TRFC_NS 80
`define LPD_TXSR_NS 120
`define LPD_CYC(ns) (((ns) * `LPD_CLK_MHZ + 999) / 1000)
`define LPD_TRP_CYC `LPD_CYC(`LPD_TRP_NS)
`define LPD_TRAS_CYC `LPD_CYC(`LPD_TRAS_NS)
`define LPD_TRFC_CYC `LPD_CYC(`LPD_TRFC_NS)
`define LPD_TXSR_CYC `LPD_CYC(`LPD_TXSR_NS)
// Longest refresh interval in ps, rounded down
`define LPD_REFI_PS 7812500
`define LPD_REFI_CYC (`LPD_REFI_PS * `LPD_CLK_MHZ / 1000000)
// Least power-up pause in ns
`define LPD_POWERUP_NS 200000
`define LPD_POWERUP_CYC `LPD_CYC(`LPD_POWERUP_NS)
`define LPD_INIT_REFS 2'h2
`define LPD_REF_LIMIT 4'h8

`endif

// ===== lpd_pkg.sv
/*
  Types shared by both ends of the low-power DDR command link.
  Assumes nothing of its surroundings.
*/
package lpd_pkg;
  typedef enum logic [1:0] {
    md_normal, md_self, md_xsr, md_dpd
  } lpd_mode_type;
  typedef enum logic [1:0] {
    cs_power_wait, cs_run, cs_self, cs_dpd
  } lpd_ctrl_state_type;
  typedef enum logic [2:0] {
    uc_activate, uc_read, uc_write, uc_precharge,
    uc_terminate, uc_self_refresh, uc_deep_power_down
  } lpd_user_cmd_type;
endpackage

// ===== lpd_link_if.sv
/*
  Command pins between memory controller and memory device.
  Assumes the controller drives every signal and makes the clock.
*/
`timescale 1ns/10ps
`default_nettype none
interface lpd_link_if;
  logic mem_clk;
  logic cke;
  logic cs_n;
  logic ras_n;
  logic cas_n;
  logic we_n;
  logic [1:0] ba;
  logic [12:0] addr;
  modport ctrl (output mem_clk, cke, cs_n, ras_n, cas_n, we_n, ba, addr);
  modport mem (input mem_clk, cke, cs_n, ras_n, cas_n, we_n, ba, addr);
endinterface
`default_nettype wire

// ===== lpd_mem_end.sv
/*
  Device end: bank states, precharge, auto precharge, burst stop,
  refresh counter, self refresh and deep power down.
  Assumes the link pins come from another clock domain.
*/
`timescale 1ns/10ps
`default_nettype none
`include "lpd_cfg.svh"

// What this block and the controller end do
// - PRECHARGE closes one bank, or all
// - Controller waits precharge time before activate
// - Idle bank needs activate before access
// - Precharge on closed bank is no-op
// - Other bank accessible during auto precharge
// - A10 on access precharges after burst
// - Auto precharge waits burst end, row time
// - No command to bank during precharge
// - Burst stop cuts latest plain read
// - Row stays open after burst stop
// - Auto refresh uses internal row counter
// - Controller refreshes every 7.8125us average
// - Clock enable high through refresh period
// - Self refresh ignores all but enable
// - Self refresh covers partial array setting
// - Self refresh exit: stable clock, NOPs
// - Deep power down loses data, reinitialize
// - Power-up wait 200us, two refreshes
// - Repeat wake-up when refresh overdue
// - Refresh encoding, enable picks auto/self
// - Precharge encoding sampled on rising edge
// - Stop encoding, enable picks deep sleep
module lpd_mem_end #(
  parameter int BURST_LEN = 4,
  parameter int SR_SLOW_CYC = 400,
  parameter int SR_FAST_CYC = 200
) (
  input wire logic i_clk, // Core clock
  input wire logic i_reset, // Sync reset, high
  lpd_link_if.mem link, // Command pins
  input wire logic [2:0] i_partial_array_refresh_setting, // Array part
  input wire logic i_temp_hot, // Faster self refresh
  output logic [3:0] o_bank_open, // Row open per bank
  output logic o_burst_active, // Burst running
  output logic o_cmd_error, // Illegal command pulse
  output logic o_refresh_pulse, // One row refreshed
  output logic [12:0] o_refresh_row, // Row refreshed
  output logic [3:0] o_refresh_banks, // Banks refreshed
  output logic o_self_refresh, // In self refresh
  output logic o_deep_power_down_mode, // In deep power down
  output logic o_init_needed // Contents lost
);

  if (BURST_LEN < 2 || BURST_LEN > 16 || BURST_LEN % 2 != 0) begin : g_chk
    $error("BURST_LEN must be even, 2 to 16");
  end
  if (SR_SLOW_CYC < 1 || SR_SLOW_CYC > 65535 || SR_FAST_CYC < 1 ||
      SR_FAST_CYC > 65535) begin : g_chk_sr
    $error("Self refresh periods out of range");
  end

  // ----------------------------------------------------------------
  // Pin sampling
  // ----------------------------------------------------------------
  logic [20:0] pin_raw, s1, s2, s3, pin_q, next_pin;
  assign pin_raw = {link.mem_clk, link.cke, link.cs_n, link.ras_n,
                    link.cas_n, link.we_n, link.ba, link.addr};
  assign next_pin = (s2 & s3) | (pin_q & (s2 | s3));

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      s1 <= '0;
      s2 <= '0;
      s3 <= '0;
      pin_q <= '0;
    end else begin
      s1 <= pin_raw;
      s2 <= s1;
      s3 <= s2;
      pin_q <= next_pin;
    end
  end

  // ----------------------------------------------------------------
  // Command decode
  // ----------------------------------------------------------------
  lpd_pkg::lpd_mode_type mode;
  logic rise, cke, sel, a10;
  logic [2:0] rcw;
  logic [1:0] ba;
  logic is_act, is_rd, is_wr, is_bt, is_pre, is_ref, is_sre, is_dpd;
  logic rw_ok, act_ok, xsr_bad;
  logic [3:0] bank_open, ap_pend, pre_start, ap_fire, pre_busy;

  assign rise = next_pin[20] & ~pin_q[20];
  assign cke = next_pin[19];
  assign rcw = next_pin[17:15];
  assign ba = next_pin[14:13];
  assign a10 = next_pin[`LPD_A10];
  assign sel = rise & ~next_pin[18] & (mode == lpd_pkg::md_normal);
  assign is_act = sel & cke & (rcw == `LPD_RCW_ACT);
  assign is_rd = sel & cke & (rcw == `LPD_RCW_RD);
  assign is_wr = sel & cke & (rcw == `LPD_RCW_WR);
  assign is_bt = sel & cke & (rcw == `LPD_RCW_BT);
  assign is_pre = sel & cke & (rcw == `LPD_RCW_PRE);
  assign is_ref = sel & cke & (rcw == `LPD_RCW_REF);
  assign is_sre = sel & ~cke & (rcw == `LPD_RCW_REF);
  assign is_dpd = sel & ~cke & (rcw == `LPD_RCW_BT);
  // Other banks stay open to access while one auto-precharges
  assign rw_ok = (is_rd | is_wr) & bank_open[ba] & ~ap_pend[ba];
  assign act_ok = is_act & ~bank_open[ba] & ~pre_busy[ba];
  assign xsr_bad = rise & ~next_pin[18] & (rcw != `LPD_RCW_NOP) &
                   (mode == lpd_pkg::md_xsr);

  // ----------------------------------------------------------------
  // Burst tracking
  // ----------------------------------------------------------------
  logic [4:0] burst_cnt;
  logic [1:0] burst_bank;
  logic burst_rd, burst_ap;

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      burst_cnt <= 5'h00;
      burst_bank <= 2'h0;
      burst_rd <= 1'b0;
      burst_ap <= 1'b0;
    end else if (rw_ok) begin
      burst_cnt <= 5'(BURST_LEN / 2);
      burst_bank <= ba;
      burst_rd <= is_rd;
      burst_ap <= a10;
    end else if (is_bt && burst_rd && !burst_ap) begin
      burst_cnt <= 5'h00;
    end else if (rise && burst_cnt != 5'h00) begin
      burst_cnt <= burst_cnt - 5'h01;
    end
  end

  // ----------------------------------------------------------------
  // Bank states
  // ----------------------------------------------------------------
  genvar b;
  for (b = 0; b < 4; b++) begin : g_bank
    logic hit;
    logic [7:0] pre_cnt, tras_cnt;
    assign hit = (ba == 2'(b));
    assign pre_busy[b] = (pre_cnt != 8'h00);
    // Starts once the burst is through and the row time is met
    assign ap_fire[b] = ap_pend[b] & (tras_cnt == 8'h00) &
                        ~((burst_cnt != 5'h00) & (burst_bank == 2'(b)));
    // Closed or closing bank ignores the precharge
    assign pre_start[b] = (is_pre & (a10 | hit) & bank_open[b]) |
                          ap_fire[b];

    always_ff @(posedge i_clk) begin
      if (i_reset) begin
        bank_open[b] <= 1'b0;
      end else if (pre_start[b] || is_dpd) begin
        bank_open[b] <= 1'b0;
      end else if (act_ok && hit) begin
        bank_open[b] <= 1'b1;
      end
    end

    always_ff @(posedge i_clk) begin
      if (i_reset) begin
        ap_pend[b] <= 1'b0;
      end else if (rw_ok && hit && a10) begin
        ap_pend[b] <= 1'b1;
      end else if (ap_fire[b]) begin
        ap_pend[b] <= 1'b0;
      end
    end

    always_ff @(posedge i_clk) begin
      if (i_reset) begin
        pre_cnt <= 8'h00;
        tras_cnt <= 8'h00;
      end else begin
        if (pre_start[b]) begin
          pre_cnt <= 8'(`LPD_TRP_CYC);
        end else if (pre_busy[b]) begin
          pre_cnt <= pre_cnt - 8'h01;
        end
        if (act_ok && hit) begin
          tras_cnt <= 8'(`LPD_TRAS_CYC);
        end else if (tras_cnt != 8'h00) begin
          tras_cnt <= tras_cnt - 8'h01;
        end
      end
    end
  end
  assign o_bank_open = bank_open;

  // ----------------------------------------------------------------
  // Power modes
  // ----------------------------------------------------------------
  logic [7:0] xsr_cnt;
  logic [15:0] sr_cnt;
  logic [1:0] init_refs;
  logic ref_auto, sr_tick;
  assign ref_auto = is_ref & ~|bank_open;
  assign sr_tick = (mode == lpd_pkg::md_self) & (sr_cnt == 16'h0000);

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      mode <= lpd_pkg::md_normal;
      xsr_cnt <= 8'h00;
    end else begin
      case (mode)
        lpd_pkg::md_normal: begin
          if (is_sre && !(|bank_open)) begin
            mode <= lpd_pkg::md_self;
          end else if (is_dpd && !(|bank_open)) begin
            mode <= lpd_pkg::md_dpd;
          end
        end
        lpd_pkg::md_self: begin
          if (cke) begin
            mode <= lpd_pkg::md_xsr;
            xsr_cnt <= 8'(`LPD_TXSR_CYC);
          end
        end
        lpd_pkg::md_xsr: begin
          if (xsr_cnt <= 8'h01) begin
            mode <= lpd_pkg::md_normal;
          end
          xsr_cnt <= xsr_cnt - 8'h01;
        end
        lpd_pkg::md_dpd: begin
          if (cke) begin
            mode <= lpd_pkg::md_normal;
          end
        end
        default: mode <= lpd_pkg::md_normal;
      endcase
    end
  end

  // Contents are lost until two refreshes follow
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      o_init_needed <= 1'b1;
      init_refs <= 2'h0;
    end else if (is_dpd) begin
      o_init_needed <= 1'b1;
      init_refs <= 2'h0;
    end else if (ref_auto && o_init_needed) begin
      init_refs <= init_refs + 2'h1;
      if (init_refs + 2'h1 == `LPD_INIT_REFS) begin
        o_init_needed <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Refresh
  // ----------------------------------------------------------------
  logic [12:0] ref_row;
  logic [3:0] partial_array_refresh_setting_mask;
  always_comb begin
    case (i_partial_array_refresh_setting)
      `LPD_PARTIAL_ARRAY_REFRESH_SETTING_HALF: partial_array_refresh_setting_mask = `LPD_BANKS_HALF;
      `LPD_PARTIAL_ARRAY_REFRESH_SETTING_QUARTER: partial_array_refresh_setting_mask = `LPD_BANKS_QUARTER;
      default: partial_array_refresh_setting_mask = `LPD_BANKS_ALL;
    endcase
  end

  // Oscillator period follows temperature
  always_ff @(posedge i_clk) begin
    if (i_reset || mode != lpd_pkg::md_self || sr_cnt == 16'h0000) begin
      sr_cnt <= i_temp_hot ? 16'(SR_FAST_CYC) : 16'(SR_SLOW_CYC);
    end else begin
      sr_cnt <= sr_cnt - 16'h0001;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      ref_row <= 13'h0000;
      o_refresh_row <= 13'h0000;
      o_refresh_banks <= 4'h0;
      o_refresh_pulse <= 1'b0;
    end else begin
      o_refresh_pulse <= ref_auto | sr_tick;
      if (ref_auto || sr_tick) begin
        ref_row <= ref_row + 13'h0001;
        o_refresh_row <= ref_row;
        o_refresh_banks <= ref_auto ? `LPD_BANKS_ALL : partial_array_refresh_setting_mask;
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      o_cmd_error <= 1'b0;
      o_burst_active <= 1'b0;
      o_self_refresh <= 1'b0;
      o_deep_power_down_mode <= 1'b0;
    end else begin
      o_cmd_error <= ((is_rd | is_wr) & ~rw_ok) | (is_act & ~act_ok) |
                     (is_ref & |bank_open) | xsr_bad;
      o_burst_active <= (burst_cnt != 5'h00);
      o_self_refresh <= (mode == lpd_pkg::md_self);
      o_deep_power_down_mode <= (mode == lpd_pkg::md_dpd);
    end
  end

endmodule // lpd_mem_end
`default_nettype wire

// ===== lpd_ctrl_end.sv
/*
  Controller end: makes the memory clock, runs power-up and refresh
  scheduling, tracks banks and turns user requests into commands.
  Assumes the user holds a request until acknowledged or refused.
*/
`timescale 1ns/10ps
`default_nettype none
`include "lpd_cfg.svh"

module lpd_ctrl_end #(
  parameter int POWER_UP_CYC = `LPD_POWERUP_CYC,
  parameter int CLK_DIV = 8,
  parameter int BURST_LEN = 4
) (
  input wire logic i_clk, // Core clock
  input wire logic i_reset, // Sync reset, high
  lpd_link_if.ctrl link, // Command pins
  input wire logic i_req, // Request held
  input wire lpd_pkg::lpd_user_cmd_type i_cmd, // Request kind
  input wire logic [1:0] i_bank, // Target bank
  input wire logic [12:0] i_addr, // Row or column
  input wire logic i_auto_pre, // Precharge after burst
  input wire logic i_all_banks, // Precharge all
  input wire logic i_wake, // Leave low power
  output logic o_ack, // Request sent pulse
  output logic o_reject, // Request refused pulse
  output logic o_init_done, // Ready for traffic
  output logic o_low_power // Self refresh or deep sleep
);

  if (CLK_DIV < 8 || CLK_DIV > 64 || CLK_DIV % 2 != 0 ||
      POWER_UP_CYC < 1 || POWER_UP_CYC > 65535 ||
      BURST_LEN < 2 || BURST_LEN > 16) begin : g_chk
    $error("lpd_ctrl_end parameters out of range");
  end

  // ----------------------------------------------------------------
  // Clock divider
  // ----------------------------------------------------------------
  logic [7:0] div_cnt;
  logic half, fall, mclk;
  assign half = (div_cnt == 8'(CLK_DIV / 2 - 1)) ||
                (div_cnt == 8'(CLK_DIV - 1));
  assign fall = half & mclk;

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      div_cnt <= 8'h00;
      mclk <= 1'b0;
    end else begin
      div_cnt <= (div_cnt == 8'(CLK_DIV - 1)) ? 8'h00 : div_cnt + 8'h01;
      if (half) begin
        mclk <= ~mclk;
      end
    end
  end
  assign link.mem_clk = mclk;

  // ----------------------------------------------------------------
  // Command choice
  // ----------------------------------------------------------------
  lpd_pkg::lpd_ctrl_state_type state, next_state;
  logic [15:0] wait_cnt, pw_cnt;
  logic [3:0] bank_open, bank_ready, ref_owed;
  logic [1:0] init_left;
  logic go, iss_ref, take, refuse, next_cs_n, next_cke, cke;
  logic [2:0] next_rcw;
  logic [12:0] next_addr;
  assign go = fall & (wait_cnt == 16'h0000);

  always_comb begin
    next_state = state;
    next_cs_n = 1'b1;
    next_rcw = `LPD_RCW_NOP;
    next_addr = i_addr;
    next_cke = cke;
    iss_ref = 1'b0;
    take = 1'b0;
    refuse = 1'b0;
    case (state)
      lpd_pkg::cs_power_wait: begin
        next_cke = 1'b1;
        if (pw_cnt == 16'h0000) begin
          next_state = lpd_pkg::cs_run;
        end
      end
      lpd_pkg::cs_run: begin
        if (go && (init_left != 2'h0 || ref_owed != 4'h0)) begin
          if (|bank_open) begin
            next_cs_n = 1'b0;
            next_rcw = `LPD_RCW_PRE;
            next_addr[`LPD_A10] = 1'b1;
          end else if (&bank_ready) begin
            next_cs_n = 1'b0;
            next_rcw = `LPD_RCW_REF;
            iss_ref = 1'b1;
          end
        end else if (go && i_req) begin
          take = 1'b1;
          next_cs_n = 1'b0;
          case (i_cmd)
            lpd_pkg::uc_activate: begin
              take = ~bank_open[i_bank] & bank_ready[i_bank];
              next_rcw = `LPD_RCW_ACT;
            end
            lpd_pkg::uc_read, lpd_pkg::uc_write: begin
              take = bank_open[i_bank] & bank_ready[i_bank];
              next_rcw = (i_cmd == lpd_pkg::uc_read) ? `LPD_RCW_RD :
                         `LPD_RCW_WR;
              next_addr[`LPD_A10] = i_auto_pre;
            end
            lpd_pkg::uc_precharge: begin
              next_rcw = `LPD_RCW_PRE;
              next_addr[`LPD_A10] = i_all_banks;
            end
            lpd_pkg::uc_terminate: next_rcw = `LPD_RCW_BT;
            default: begin
              take = ~|bank_open & (&bank_ready);
              next_rcw = (i_cmd == lpd_pkg::uc_self_refresh) ?
                         `LPD_RCW_REF : `LPD_RCW_BT;
              next_cke = ~take;
              if (take) begin
                next_state = (i_cmd == lpd_pkg::uc_self_refresh) ?
                             lpd_pkg::cs_self : lpd_pkg::cs_dpd;
              end
            end
          endcase
          refuse = ~take;
          if (!take) begin
            next_cs_n = 1'b1;
            next_rcw = `LPD_RCW_NOP;
          end
        end
      end
      lpd_pkg::cs_self: begin
        if (go && i_wake) begin
          next_cke = 1'b1;
          next_state = lpd_pkg::cs_run;
        end
      end
      lpd_pkg::cs_dpd: begin
        if (go && i_wake) begin
          next_cke = 1'b1;
          next_state = lpd_pkg::cs_power_wait;
        end
      end
      default: next_state = lpd_pkg::cs_power_wait;
    endcase
  end

  // ----------------------------------------------------------------
  // Sequencing and timers
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      state <= lpd_pkg::cs_power_wait;
      wait_cnt <= 16'h0000;
      pw_cnt <= 16'(POWER_UP_CYC);
    end else begin
      state <= next_state;
      if (iss_ref) begin
        wait_cnt <= 16'(`LPD_TRFC_CYC);
      end else if (state == lpd_pkg::cs_self &&
                   next_state == lpd_pkg::cs_run) begin
        wait_cnt <= 16'(`LPD_TXSR_CYC);
      end else if (wait_cnt != 16'h0000) begin
        wait_cnt <= wait_cnt - 16'h0001;
      end
      if (state == lpd_pkg::cs_dpd) begin
        pw_cnt <= 16'(POWER_UP_CYC);
      end else if (pw_cnt != 16'h0000) begin
        pw_cnt <= pw_cnt - 16'h0001;
      end
    end
  end

  // Refresh debt; an overdue backlog repeats the wake-up pair
  logic [11:0] ref_timer;
  logic ref_tick;
  assign ref_tick = (ref_timer == 12'(`LPD_REFI_CYC - 1));

  always_ff @(posedge i_clk) begin
    if (i_reset || state != lpd_pkg::cs_run) begin
      ref_timer <= 12'h000;
      ref_owed <= 4'h0;
      init_left <= `LPD_INIT_REFS;
    end else begin
      ref_timer <= ref_tick ? 12'h000 : ref_timer + 12'h001;
      if (ref_tick && ref_owed == `LPD_REF_LIMIT) begin
        ref_owed <= 4'h0;
        init_left <= `LPD_INIT_REFS;
      end else if (init_left != 2'h0) begin
        init_left <= init_left - 2'(iss_ref);
        ref_owed <= ref_owed + 4'(ref_tick);
      end else begin
        ref_owed <= ref_owed + 4'(ref_tick) - 4'(iss_ref);
      end
    end
  end

  genvar b;
  for (b = 0; b < 4; b++) begin : g_bank
    logic hit, pre_hit, ap_hit;
    logic [9:0] bank_wait;
    assign hit = (i_bank == 2'(b));
    assign pre_hit = (next_rcw == `LPD_RCW_PRE) & fall & ~next_cs_n &
                     (next_addr[`LPD_A10] | hit);
    assign ap_hit = take & hit & i_auto_pre &
                    (i_cmd == lpd_pkg::uc_read || i_cmd == lpd_pkg::uc_write);
    assign bank_ready[b] = (bank_wait == 10'h000);

    always_ff @(posedge i_clk) begin
      if (i_reset) begin
        bank_open[b] <= 1'b0;
        bank_wait <= 10'h000;
      end else begin
        if (pre_hit || ap_hit) begin
          bank_open[b] <= 1'b0;
        end else if (take && hit && i_cmd == lpd_pkg::uc_activate) begin
          bank_open[b] <= 1'b1;
        end
        if (pre_hit) begin
          bank_wait <= 10'(`LPD_TRP_CYC);
        end else if (ap_hit) begin
          bank_wait <= 10'(`LPD_TRAS_CYC + `LPD_TRP_CYC +
                           BURST_LEN / 2 * CLK_DIV);
        end else if (bank_wait != 10'h000) begin
          bank_wait <= bank_wait - 10'h001;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Pin and status registers
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      cke <= 1'b1;
      link.cs_n <= 1'b1;
      {link.ras_n, link.cas_n, link.we_n} <= `LPD_RCW_NOP;
      link.ba <= 2'h0;
      link.addr <= 13'h0000;
    end else if (fall) begin
      cke <= next_cke;
      link.cs_n <= next_cs_n;
      {link.ras_n, link.cas_n, link.we_n} <= next_rcw;
      link.ba <= i_bank;
      link.addr <= next_addr;
    end
  end
  assign link.cke = cke;

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      o_ack <= 1'b0;
      o_reject <= 1'b0;
      o_init_done <= 1'b0;
      o_low_power <= 1'b0;
    end else begin
      o_ack <= take;
      o_reject <= refuse;
      o_init_done <= (state == lpd_pkg::cs_run) && (init_left == 2'h0);
      o_low_power <= (state == lpd_pkg::cs_self) ||
                     (state == lpd_pkg::cs_dpd);
    end
  end

endmodule // lpd_ctrl_end
`default_nettype wire

// ===== lpd_link_assertions.sv
/* Checks on the link pins and device state.
   Assumes CLK_DIV 8 and the 200 MHz core clock. */
`timescale 1ns/10ps
`default_nettype none
`include "lpd_cfg.svh"
module lpd_link_assertions (
  input wire logic i_clk, // Clock
  input wire logic i_reset, // Reset
  input wire logic mem_clk, // Link clock
  input wire logic cke, // Enable
  input wire logic cs_n, // Select
  input wire logic ras_n, // Row
  input wire logic cas_n, // Column
  input wire logic we_n, // Write
  input wire logic [1:0] ba, // Bank
  input wire logic [12:0] addr, // Address
  input wire logic [3:0] o_bank_open, // Rows
  input wire logic o_self_refresh, // Self
  input wire logic o_deep_power_down_mode // Sleep
);
  // --------
  // Checks
  // --------
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_reset);
  logic mc_q;
  always_ff @(posedge i_clk) mc_q <= mem_clk;
  wire logic [2:0] rcw = {ras_n, cas_n, we_n};
  wire logic go = mem_clk && !mc_q && !cs_n;
  wire logic nop = cs_n || rcw == `LPD_RCW_NOP;
  AST_PIN_HOLD: assert property (
    $rose(mem_clk) |-> $stable({cs_n, rcw, ba, addr})) else $error("pins");
  AST_REF_CKE: assert property (
    go && rcw == `LPD_RCW_REF && cke |-> cke[*8] ##1 cke[*8])
    else $error("cke");
  AST_REF_IDLE: assert property (
    go && rcw == `LPD_RCW_REF && cke |-> o_bank_open == 4'h0)
    else $error("open");
  AST_XSR_NOP: assert property (
    $rose(cke) |-> nop[*8] ##1 nop[*8] ##1 nop[*8]) else $error("xsr");
  AST_PRE_ALL: assert property (
    go && rcw == `LPD_RCW_PRE && addr[`LPD_A10] && cke
    |-> ##[2:6] o_bank_open == 4'h0) else $error("pre");
  AST_SELF_IN: assert property (
    go && rcw == `LPD_RCW_REF && !cke |-> ##[2:6] o_self_refresh)
    else $error("self");
  AST_DPD_IN: assert property (
    go && rcw == `LPD_RCW_BT && !cke |-> ##[2:6] o_deep_power_down_mode)
    else $error("dpd");
  AST_BT_OPEN: assert property (
    go && rcw == `LPD_RCW_BT && cke && o_bank_open != 4'h0
    |-> ##6 o_bank_open != 4'h0) else $error("bt");
endmodule // lpd_link_assertions
`default_nettype wire

// ===== test_lpddr_precharge_refresh_power_cmds.sv
/* Bench joining controller and device ends.
   Assumes lpd_pkg and the link interface. */
`timescale 1ns/10ps
`default_nettype none
module test_lpddr_precharge_refresh_power_cmds;
  logic i_clk = 0, i_reset = 1, i_req = 0, ap = 0, al = 0, i_wake = 0;
  logic o_ack, o_reject, o_init_done, o_low_power, err, rp, sr, deep_power_down_mode, inn, bu;
  logic [1:0] i_bank = 2'h0;
  logic [2:0] partial_array_refresh_setting = 3'h0;
  logic [3:0] bo, rb;
  logic [12:0] row, last;
  lpd_pkg::lpd_user_cmd_type i_cmd = lpd_pkg::uc_activate;
  int bad_count = 0, compares = 0, cyc = 0, nref = 0, nerr = 0;
  lpd_link_if link ();
  lpd_ctrl_end #(.POWER_UP_CYC(200)) lpd_ctrl_end_i (.i_clk, .i_reset,
    .link(link.ctrl), .i_req, .i_cmd, .i_bank, .i_addr(13'h0000),
    .i_auto_pre(ap), .i_all_banks(al), .i_wake, .o_ack, .o_reject,
    .o_init_done, .o_low_power);
  lpd_mem_end #(.SR_SLOW_CYC(100)) lpd_mem_end_i (.i_clk, .i_reset,
    .link(link.mem), .i_partial_array_refresh_setting(partial_array_refresh_setting),
    .i_temp_hot(1'h0), .o_bank_open(bo), .o_burst_active(bu),
    .o_cmd_error(err), .o_refresh_pulse(rp), .o_refresh_row(row),
    .o_refresh_banks(rb), .o_self_refresh(sr),
    .o_deep_power_down_mode(deep_power_down_mode), .o_init_needed(inn));
  lpd_link_assertions lpd_link_assertions_i (.i_clk, .i_reset,
    .mem_clk(link.mem_clk), .cke(link.cke), .cs_n(link.cs_n),
    .ras_n(link.ras_n), .cas_n(link.cas_n), .we_n(link.we_n),
    .ba(link.ba), .addr(link.addr), .o_bank_open(bo),
    .o_self_refresh(sr), .o_deep_power_down_mode(deep_power_down_mode));
  initial forever #2.5 i_clk = ~i_clk;
  // ----------
  // Tasks
  // ----------
  task automatic chk(string n, logic [12:0] e, logic [12:0] g);
    compares++;
    if (g !== e) begin
      bad_count++;
      $display("CHECK FAILED %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic send(lpd_pkg::lpd_user_cmd_type c, logic [1:0] b,
                      logic a, logic l, logic ex);
    @(posedge i_clk) #1;
    i_cmd = c;
    i_bank = b;
    ap = a;
    al = l;
    i_req = 1;
    do @(posedge i_clk) #1; while (o_ack !== 1'b1 && o_reject !== 1'b1);
    chk("ack", 13'(ex), 13'(o_ack));
    i_req = 0;
    repeat (12) @(posedge i_clk);
    #1;
  endtask
  task automatic tally_and_finish(bit t);
    if (t) bad_count++;
    $display("TB: compares %0d bad %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  always @(negedge i_clk) begin
    cyc++;
    if (err === 1'b1) nerr++;
    if (rp === 1'b1) begin
      if (nref > 0 && sr !== 1'b1 && inn !== 1'b1)
        chk("row", last + 13'h1, row);
      chk("banks", sr ? 13'h1 : 13'hF, 13'(rb));
      last = row;
      nref++;
    end
    if (cyc > 10000) tally_and_finish(1);
  end
  // ----------
  // Sequence
  // ----------
  initial begin
    repeat (16) @(posedge i_clk);
    #1 i_reset = 0;
    wait (o_init_done === 1'b1);
    repeat (12) @(posedge i_clk);
    #1 chk("init", 13'h0, 13'(inn));
    send(lpd_pkg::uc_activate, 2'h0, 0, 0, 1);
    chk("open", 13'h1, 13'(bo));
    send(lpd_pkg::uc_read, 2'h1, 0, 0, 0);
    send(lpd_pkg::uc_activate, 2'h1, 0, 0, 1);
    send(lpd_pkg::uc_precharge, 2'h0, 0, 1, 1);
    chk("all", 13'h0, 13'(bo));
    send(lpd_pkg::uc_precharge, 2'h2, 0, 0, 1);
    send(lpd_pkg::uc_activate, 2'h2, 0, 0, 1);
    send(lpd_pkg::uc_activate, 2'h3, 0, 0, 1);
    send(lpd_pkg::uc_read, 2'h2, 1, 0, 1);
    send(lpd_pkg::uc_write, 2'h3, 1, 0, 1);
    repeat (40) @(posedge i_clk);
    #1 chk("auto", 13'h0, 13'(bo));
    send(lpd_pkg::uc_activate, 2'h0, 0, 0, 1);
    send(lpd_pkg::uc_read, 2'h0, 0, 0, 1);
    chk("burst", 13'h1, 13'(bu));
    send(lpd_pkg::uc_terminate, 2'h0, 0, 0, 1);
    chk("kept", 13'h1, 13'(bo));
    chk("stopped", 13'h0, 13'(bu));
    send(lpd_pkg::uc_precharge, 2'h0, 0, 0, 1);
    chk("one", 13'h0, 13'(bo));
    partial_array_refresh_setting = 3'h2;
    send(lpd_pkg::uc_self_refresh, 2'h0, 0, 0, 1);
    chk("self", 13'h1, 13'(sr));
    repeat (300) @(posedge i_clk);
    #1 i_wake = 1;
    wait (o_low_power === 1'b0);
    @(posedge i_clk) #1 i_wake = 0;
    repeat (40) @(posedge i_clk);
    #1 chk("wake", 13'h0, 13'(sr));
    send(lpd_pkg::uc_deep_power_down, 2'h0, 0, 0, 1);
    chk("dpd", 13'h1, 13'(deep_power_down_mode));
    chk("lost", 13'h1, 13'(inn));
    i_wake = 1;
    wait (o_low_power === 1'b0);
    @(posedge i_clk) #1 i_wake = 0;
    wait (o_init_done === 1'b0);
    wait (o_init_done === 1'b1);
    repeat (12) @(posedge i_clk);
    #1 chk("reinit", 13'h0, 13'(inn));
    repeat (3200) @(posedge i_clk);
    chk("errors", 13'h0, 13'(nerr));
    tally_and_finish(0);
  end
endmodule // test_lpddr_precharge_refresh_power_cmds
`default_nettype wire
